//--- src/ssi_top.sv
// ssi top: pin sync, angle indexer, standby and fault, ahb-lite registers
`include "ssi_defs.svh"

// Functional notes
// - each rising step edge advances angle one step; falling edge does nothing
// - output enable high drives motor outputs; low puts them high impedance
// - direction high steps clockwise, a leads b; low steps ccw, b leads
// - angle reset high forces the home angle; low lets stepping proceed
// - home is 45 degrees: 100% in full and half a, else 71%
// - home flag is driven low while angle reset is applied
// - select pins decode to full, half a, quarter, half b, 1/8..1/32
// - all selects low: standby, oscillator and outputs off, full step
// - standby cuts bias current and suspends internal functions
// - entering standby clears the latched thermal and overcurrent fault
// - entering standby returns the angle to its home position
// - home flag pulled low at home angle, released otherwise
// - fault output released normally, pulled low once a fault is latched
module ssi_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic step_clk,
  input wire logic direction_select,
  input wire logic out_enable,
  input wire logic angle_reset,
  input wire logic step_res_sel0,
  input wire logic step_res_sel1,
  input wire logic step_res_sel2,
  input wire logic thermal_shutdown_fault,
  input wire logic overcurrent_fault,
  output logic out_a_pos,
  output logic out_a_neg,
  output logic out_b_pos,
  output logic out_b_neg,
  output logic [3:0] motor_oe_n,
  output ssi_pkg::ssi_ratio_t cur_a,
  output ssi_pkg::ssi_ratio_t cur_b,
  output logic osc_enable,
  output logic bias_enable,
  output logic home_angle_flag_o,
  output logic home_angle_flag_oe_n,
  output logic fault_o,
  output logic fault_oe_n,
  output logic irq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;

  assign pin_raw = {overcurrent_fault, thermal_shutdown_fault,
                    step_res_sel2, step_res_sel1, step_res_sel0,
                    angle_reset, out_enable, direction_select, step_clk};

  for (genvar i = 0; i < NPIN; i++)
  begin : g_sync
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end
      else if (ce)
      begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic step_s;
  logic dir_s;
  logic en_s;
  logic arst_s;
  logic fault_in_s;
  ssi_pkg::ssi_res_e res_w;
  logic stby_w;

  assign step_s = sync2_q[0];
  assign dir_s = sync2_q[1];
  assign en_s = sync2_q[2];
  assign arst_s = sync2_q[3];
  assign res_w = ssi_pkg::ssi_res_e'({sync2_q[4], sync2_q[5], sync2_q[6]});
  assign stby_w = (res_w == ssi_pkg::RES_STBY);
  assign fault_in_s = sync2_q[7] | sync2_q[8];

  // ----------------------------------------------------------------
  // angle indexer, standby and fault latch
  // ----------------------------------------------------------------
  logic step_prev_q, step_prev_d;
  ssi_pkg::ssi_angle_t angle_q, angle_d;
  ssi_pkg::ssi_res_e res_q, res_d;
  logic stby_q, stby_d;
  logic [`SSI_STARTUP_W-1:0] startup_q, startup_d;
  logic fault_q, fault_d;
  logic drive_q, drive_d;
  logic [3:0] phase_q, phase_d;
  ssi_pkg::ssi_ratio_t cur_a_q, cur_a_d, cur_b_q, cur_b_d;
  logic home_oe_n_q, home_oe_n_d;
  logic [31:0] steps_q, steps_d;
  logic hold_q;
  logic step_rise;
  logic step_fall;
  logic step_take;
  ssi_pkg::ssi_angle_t inc_w;
  ssi_pkg::ssi_ratio_t mag_a, mag_b;
  logic neg_a, neg_b;

  assign step_rise = step_s & ~step_prev_q;
  assign step_fall = ~step_s & step_prev_q;
  // steps are ignored while the core restarts after standby
  assign step_take = step_rise && !stby_w && !arst_s && !hold_q &&
                     (startup_q == '0);

  always_comb
  begin
    case (res_w)
      ssi_pkg::RES_FULL: inc_w = `SSI_INC_FULL;
      ssi_pkg::RES_HALF_A: inc_w = `SSI_INC_HALF;
      ssi_pkg::RES_HALF_B: inc_w = `SSI_INC_HALF;
      ssi_pkg::RES_QUARTER: inc_w = `SSI_INC_QUARTER;
      ssi_pkg::RES_EIGHTH: inc_w = `SSI_INC_EIGHTH;
      ssi_pkg::RES_SIXTEENTH: inc_w = `SSI_INC_SIXTEENTH;
      ssi_pkg::RES_THIRTYSECOND: inc_w = `SSI_INC_THIRTYSECOND;
      default: inc_w = '0;
    endcase
  end

  ssi_phase_table u_table
  (
    .angle(angle_d),
    .res(res_d),
    .mag_a(mag_a),
    .mag_b(mag_b),
    .neg_a(neg_a),
    .neg_b(neg_b)
  );

  always_comb
  begin
    step_prev_d = step_s;
    stby_d = stby_w;
    // standby keeps full step as the internal logic state
    res_d = stby_w ? ssi_pkg::RES_FULL : res_w;
    angle_d = angle_q;
    if (stby_w || arst_s)
      angle_d = `SSI_HOME_IDX;
    else if (step_take && dir_s)
      angle_d = angle_q + inc_w;
    else if (step_take)
      angle_d = angle_q - inc_w;
    startup_d = startup_q;
    if (stby_w)
      startup_d = `SSI_STARTUP_W'(`SSI_STARTUP_CYC);
    else if (startup_q != '0)
      startup_d = startup_q - `SSI_STARTUP_W'(1);
    fault_d = fault_q;
    if (stby_w)
      fault_d = 1'b0;
    else if (fault_in_s)
      fault_d = 1'b1;
    drive_d = en_s && !stby_w;
    phase_d = {(mag_b != '0) & neg_b, (mag_b != '0) & ~neg_b,
               (mag_a != '0) & neg_a, (mag_a != '0) & ~neg_a};
    cur_a_d = mag_a;
    cur_b_d = mag_b;
    home_oe_n_d = (angle_d != `SSI_HOME_IDX);
    steps_d = steps_q + {31'h0000_0000, step_take};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_prev_q <= 1'b0;
      angle_q <= `SSI_HOME_IDX;
      res_q <= ssi_pkg::RES_FULL;
      stby_q <= 1'b1;
      startup_q <= `SSI_STARTUP_W'(`SSI_STARTUP_CYC);
      fault_q <= 1'b0;
      drive_q <= 1'b0;
      phase_q <= 4'h0;
      cur_a_q <= `SSI_RATIO_FULL;
      cur_b_q <= `SSI_RATIO_FULL;
      home_oe_n_q <= 1'b0;
      steps_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      step_prev_q <= step_prev_d;
      angle_q <= angle_d;
      res_q <= res_d;
      stby_q <= stby_d;
      startup_q <= startup_d;
      fault_q <= fault_d;
      drive_q <= drive_d;
      phase_q <= phase_d;
      cur_a_q <= cur_a_d;
      cur_b_q <= cur_b_d;
      home_oe_n_q <= home_oe_n_d;
      steps_q <= steps_d;
    end
  end

  assign {out_b_neg, out_b_pos, out_a_neg, out_a_pos} =
    drive_q ? phase_q : 4'h0;
  assign motor_oe_n = {4{~drive_q}};
  // oscillator and bias are cut for the whole of standby
  assign osc_enable = ~stby_q;
  assign bias_enable = ~stby_q;
  assign cur_a = cur_a_q;
  assign cur_b = cur_b_q;
  assign home_angle_flag_o = 1'b0;
  assign home_angle_flag_oe_n = home_oe_n_q;
  assign fault_o = 1'b0;
  assign fault_oe_n = ~fault_q;

  // ----------------------------------------------------------------
  // ahb-lite slave and interrupt registers
  // ----------------------------------------------------------------
  logic acc;
  logic [`SSI_IRQ_W-1:0] ev;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hold_d;
  logic [`SSI_IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [`SSI_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [31:0] status_w;

  assign acc = hsel && htrans[1] && hready;
  assign ev = {stby_w && !stby_q, (angle_d == `SSI_HOME_IDX) &&
               (angle_q != `SSI_HOME_IDX), fault_d && !fault_q, step_take};

  always_comb
  begin
    status_w = 32'h0000_0000;
    status_w[`SSI_ST_ANGLE_HI:`SSI_ST_ANGLE_LO] = angle_q;
    status_w[`SSI_ST_RES_HI:`SSI_ST_RES_LO] = res_q;
    status_w[`SSI_ST_STBY] = stby_q;
    status_w[`SSI_ST_FAULT] = fault_q;
    status_w[`SSI_ST_HOME] = ~home_oe_n_q;
    status_w[`SSI_ST_STARTUP] = (startup_q != '0);
  end

  always_comb
  begin
    wr_pend_d = acc && hwrite;
    wr_addr_d = acc ? haddr[7:0] : wr_addr_q;
    hrdata_d = hrdata_q;
    if (acc && !hwrite)
    begin
      case (haddr[7:0])
        `SSI_OFF_CTRL: hrdata_d = {31'h0000_0000, hold_q};
        `SSI_OFF_STATUS: hrdata_d = status_w;
        `SSI_OFF_IRQ_STAT: hrdata_d = {28'h000_0000, irq_stat_q};
        `SSI_OFF_IRQ_MASK: hrdata_d = {28'h000_0000, irq_mask_q};
        `SSI_OFF_STEPS: hrdata_d = steps_q;
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    hold_d = hold_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (wr_pend_q && wr_addr_q == `SSI_OFF_CTRL)
      hold_d = hwdata[`SSI_CTRL_HOLD];
    if (wr_pend_q && wr_addr_q == `SSI_OFF_IRQ_MASK)
      irq_mask_d = hwdata[`SSI_IRQ_W-1:0];
    if (wr_pend_q && wr_addr_q == `SSI_OFF_IRQ_STAT)
      irq_stat_d = irq_stat_q & ~hwdata[`SSI_IRQ_W-1:0];
    // a new event outranks a clear landing in the same cycle
    irq_stat_d = irq_stat_d | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hold_q <= `SSI_CTRL_RST;
      irq_stat_q <= 4'h0;
      irq_mask_q <= `SSI_IRQ_MASK_RST;
    end
    else if (ce)
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      hold_q <= hold_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // a frozen block stalls the bus rather than dropping a transfer
  assign hreadyout = ce;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_step_cw;
    ce && step_take && dir_s |=> angle_q == ssi_pkg::ssi_angle_t'(
      $past(angle_q) + $past(inc_w));
  endproperty
  a_step_cw: assert property (p_step_cw)
    else $error("rising step did not advance angle");

  property p_step_ccw;
    ce && step_take && !dir_s |=> angle_q == ssi_pkg::ssi_angle_t'(
      $past(angle_q) - $past(inc_w));
  endproperty
  a_step_ccw: assert property (p_step_ccw)
    else $error("ccw step did not retreat angle");

  property p_fall_still;
    ce && step_fall && !arst_s && !stby_w |=> $stable(angle_q);
  endproperty
  a_fall_still: assert property (p_fall_still)
    else $error("falling step edge moved angle");

  property p_off_hiz;
    ce && !en_s |=> motor_oe_n == 4'hF && !out_a_pos && !out_b_pos;
  endproperty
  a_off_hiz: assert property (p_off_hiz)
    else $error("outputs driven while enable low");

  property p_reset_home;
    ce && arst_s |=> angle_q == `SSI_HOME_IDX && !home_angle_flag_oe_n;
  endproperty
  a_reset_home: assert property (p_reset_home)
    else $error("angle reset did not force home");

  property p_home_flag;
    home_angle_flag_oe_n == (angle_q != `SSI_HOME_IDX);
  endproperty
  a_home_flag: assert property (p_home_flag)
    else $error("home flag disagrees with angle");

  property p_home_ratio;
    angle_q == `SSI_HOME_IDX && res_q == ssi_pkg::RES_QUARTER |->
      cur_a_q == `SSI_RATIO_HOME && cur_b_q == `SSI_RATIO_HOME;
  endproperty
  a_home_ratio: assert property (p_home_ratio)
    else $error("home current ratio wrong");

  property p_stby;
    ce && stby_w |=> motor_oe_n == 4'hF && !osc_enable && !fault_q &&
      angle_q == `SSI_HOME_IDX;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby did not shut down and reinit");

  property p_fault_latch;
    ce && fault_in_s && !stby_w |=> !fault_oe_n [*2];
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("fault not latched on output");

  property p_startup_quiet;
    ce && $fell(stby_q) |-> startup_q != '0 && !step_take;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet)
    else $error("step accepted during startup");

  c_cw_step: cover property (ce && step_take && dir_s);
  c_ccw_wrap: cover property (ce && step_take && !dir_s &&
    angle_q == 7'h00);
  c_fault_release: cover property (fault_q ##[1:20] stby_q);
  c_irq: cover property ($rose(irq));
endmodule

//--- common/ssi_defs.svh
// ssi constants: register offsets, field positions, reset values, timing
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSI_OFF_CTRL 8'h00
`define SSI_OFF_STATUS 8'h04
`define SSI_OFF_IRQ_STAT 8'h08
`define SSI_OFF_IRQ_MASK 8'h0C
`define SSI_OFF_STEPS 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSI_CTRL_HOLD 0
`define SSI_ST_ANGLE_LO 0
`define SSI_ST_ANGLE_HI 6
`define SSI_ST_RES_LO 8
`define SSI_ST_RES_HI 10
`define SSI_ST_STBY 12
`define SSI_ST_FAULT 13
`define SSI_ST_HOME 14
`define SSI_ST_STARTUP 15
`define SSI_IRQ_STEP 0
`define SSI_IRQ_FAULT 1
`define SSI_IRQ_HOME 2
`define SSI_IRQ_STBY 3
`define SSI_IRQ_W 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSI_CTRL_RST 1'h0
`define SSI_IRQ_MASK_RST 4'h0

// ----------------------------------------------------------------
// angle index and current ratios
// ----------------------------------------------------------------
`define SSI_HOME_IDX 7'h10
`define SSI_INC_FULL 7'h20
`define SSI_INC_HALF 7'h10
`define SSI_INC_QUARTER 7'h08
`define SSI_INC_EIGHTH 7'h04
`define SSI_INC_SIXTEENTH 7'h02
`define SSI_INC_THIRTYSECOND 7'h01
`define SSI_QUAD_SPAN 6'h20
`define SSI_QTR_PEAK_TH 6'h18
`define SSI_RATIO_FULL 7'h64
`define SSI_RATIO_HOME 7'h47

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSI_CLK_PERIOD_NS 10
`define SSI_STARTUP_US 10
`define SSI_STARTUP_W 10
`define SSI_STARTUP_CYC (`SSI_STARTUP_US * 1000 / `SSI_CLK_PERIOD_NS)

`endif

//--- common/ssi_pkg.sv
// ssi types: step resolution select and angle index
package ssi_pkg;
  // order matches the select pins read as {sel0, sel1, sel2}
  typedef enum logic [2:0] {
    RES_STBY,
    RES_FULL,
    RES_HALF_A,
    RES_QUARTER,
    RES_HALF_B,
    RES_EIGHTH,
    RES_SIXTEENTH,
    RES_THIRTYSECOND
  } ssi_res_e;
  typedef logic [6:0] ssi_angle_t;
  typedef logic [6:0] ssi_ratio_t;
endpackage

//--- src/ssi_phase_table.sv
// ssi phase table: angle index to per-phase current ratio and polarity
`include "ssi_defs.svh"

module ssi_phase_table
(
  input wire ssi_pkg::ssi_angle_t angle,
  input wire ssi_pkg::ssi_res_e res,
  output ssi_pkg::ssi_ratio_t mag_a,
  output ssi_pkg::ssi_ratio_t mag_b,
  output logic neg_a,
  output logic neg_b
);
  // ----------------------------------------------------------------
  // one quadrant of ratios in percent, index 0..32
  // ----------------------------------------------------------------
  localparam ssi_pkg::ssi_ratio_t RATIO [0:32] = '{
    7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1D, 7'h22,
    7'h26, 7'h2B, 7'h2F, 7'h34, 7'h38, 7'h3C, 7'h3F, 7'h43,
    7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5A,
    7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64,
    7'h64};

  function automatic ssi_pkg::ssi_ratio_t lookup(input logic [5:0] th,
      input ssi_pkg::ssi_res_e r);
    ssi_pkg::ssi_ratio_t v;
    v = RATIO[th];
    // full step, half step a and standby drive every energised phase at full torque
    if ((r == ssi_pkg::RES_FULL || r == ssi_pkg::RES_HALF_A ||
         r == ssi_pkg::RES_STBY) && v != 7'h00)
      v = `SSI_RATIO_FULL;
    if (r == ssi_pkg::RES_QUARTER && th == `SSI_QTR_PEAK_TH)
      v = `SSI_RATIO_FULL;
    return v;
  endfunction

  logic [5:0] th_lo;
  logic [5:0] th_hi;

  always_comb
  begin
    th_lo = {1'b0, angle[4:0]};
    th_hi = `SSI_QUAD_SPAN - th_lo;
    // phase a follows cosine, b sine: a leads b as the index rises
    case (angle[6:5])
      2'h0:
      begin
        mag_a = lookup(th_hi, res);
        mag_b = lookup(th_lo, res);
        neg_a = 1'b0;
        neg_b = 1'b0;
      end
      2'h1:
      begin
        mag_a = lookup(th_lo, res);
        mag_b = lookup(th_hi, res);
        neg_a = 1'b1;
        neg_b = 1'b0;
      end
      2'h2:
      begin
        mag_a = lookup(th_hi, res);
        mag_b = lookup(th_lo, res);
        neg_a = 1'b1;
        neg_b = 1'b1;
      end
      default:
      begin
        mag_a = lookup(th_lo, res);
        mag_b = lookup(th_hi, res);
        neg_a = 1'b0;
        neg_b = 1'b1;
      end
    endcase
  end
endmodule

//--- tb/ssi_ctrl_model.sv
// ssi controller model: motion controller driving step and mode pins
`include "ssi_defs.svh"

module ssi_ctrl_model
(
  input wire logic clk,
  output logic step_clk,
  output logic direction_select,
  output logic out_enable,
  output logic angle_reset,
  output logic step_res_sel0,
  output logic step_res_sel1,
  output logic step_res_sel2
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // power-up levels
  // ----------------------------------------------------------------
  initial
  begin
    step_clk = 1'b0;
    direction_select = 1'b1;
    out_enable = 1'b0;
    angle_reset = 1'b1;
    {step_res_sel0, step_res_sel1, step_res_sel2} = 3'b000;
  end

  // ----------------------------------------------------------------
  // pin tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic set_mode(input logic [2:0] code);
    logic wake;
    wake = ({step_res_sel0, step_res_sel1, step_res_sel2} == 3'b000);
    wake = wake && (code != 3'b000);
    {step_res_sel0, step_res_sel1, step_res_sel2} <= code;
    // stay quiet through the restart; margin covers the pin sync
    repeat (wake ? `SSI_STARTUP_CYC + 20 : 6) @(posedge clk);
  endtask

  task automatic set_ctl(input logic en, input logic rst, input logic dir);
    out_enable <= en;
    angle_reset <= rst;
    direction_select <= dir;
    repeat (6) @(posedge clk);
  endtask

  // hold of 2 is the shortest level the pin sync is sure to see
  task automatic step_lvl(input logic v, input int hold);
    step_clk <= v;
    repeat (hold) @(posedge clk);
  endtask

  task automatic pulse(input int n, input int hold);
    repeat (n)
    begin
      step_lvl(1'b1, hold);
      step_lvl(1'b0, hold);
    end
  endtask
endmodule

//--- tb/testbench.sv
// ssi testbench: ahb-lite register and pin level checks of ssi_top
`include "ssi_defs.svh"

`define CHK(g, e) \
  begin \
    tests_run = tests_run + 1; \
    if ((g) !== (e)) \
    begin \
      err_total = err_total + 1; \
      $display("unexpected at %0t: got %h expected %h", $time, g, e); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic step_clk, direction_select, out_enable, angle_reset;
  logic step_res_sel0, step_res_sel1, step_res_sel2;
  logic thermal_shutdown_fault, overcurrent_fault;
  logic out_a_pos, out_a_neg, out_b_pos, out_b_neg, irq;
  logic [3:0] motor_oe_n;
  ssi_pkg::ssi_ratio_t cur_a, cur_b;
  logic osc_enable, bias_enable, home_angle_flag_o, home_angle_flag_oe_n;
  logic fault_o, fault_oe_n;
  int err_total, tests_run;
  logic [6:0] exp_angle;
  logic [6:0] inc_tab [1:7] = '{`SSI_INC_FULL, `SSI_INC_HALF,
    `SSI_INC_QUARTER, `SSI_INC_HALF, `SSI_INC_EIGHTH, `SSI_INC_SIXTEENTH,
    `SSI_INC_THIRTYSECOND};
  logic [6:0] home_tab [1:7] = '{`SSI_RATIO_FULL, `SSI_RATIO_FULL,
    `SSI_RATIO_HOME, `SSI_RATIO_HOME, `SSI_RATIO_HOME, `SSI_RATIO_HOME,
    `SSI_RATIO_HOME};

  ssi_top u_ssi_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .step_clk(step_clk),
    .direction_select(direction_select), .out_enable(out_enable),
    .angle_reset(angle_reset), .step_res_sel0(step_res_sel0),
    .step_res_sel1(step_res_sel1), .step_res_sel2(step_res_sel2),
    .thermal_shutdown_fault(thermal_shutdown_fault),
    .overcurrent_fault(overcurrent_fault), .out_a_pos(out_a_pos),
    .out_a_neg(out_a_neg), .out_b_pos(out_b_pos), .out_b_neg(out_b_neg),
    .motor_oe_n(motor_oe_n), .cur_a(cur_a), .cur_b(cur_b),
    .osc_enable(osc_enable), .bias_enable(bias_enable),
    .home_angle_flag_o(home_angle_flag_o),
    .home_angle_flag_oe_n(home_angle_flag_oe_n), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .irq(irq));

  ssi_ctrl_model u_ssi_ctrl_model (.clk(hclk), .step_clk(step_clk),
    .direction_select(direction_select), .out_enable(out_enable),
    .angle_reset(angle_reset), .step_res_sel0(step_res_sel0),
    .step_res_sel1(step_res_sel1), .step_res_sel2(step_res_sel2));

  // ----------------------------------------------------------------
  // clock, bus and check tasks
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000, rd);
    `CHK(rd & m, e)
  endtask

  task automatic chk_angle();
    chk_reg(`SSI_OFF_STATUS, 32'h0000_007F, {25'h000_0000, exp_angle});
  endtask

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge hclk);
    err_total = err_total + 1;
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    tests_run = 0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    thermal_shutdown_fault = 1'b0;
    overcurrent_fault = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    // standby at power-up, registers at reset values
    `CHK(motor_oe_n, 4'hF)
    `CHK({osc_enable, bias_enable}, 2'b00)
    `CHK({cur_a, cur_b}, {`SSI_RATIO_FULL, `SSI_RATIO_FULL})
    `CHK({home_angle_flag_oe_n, fault_oe_n, irq}, 3'b010)
    `CHK({hresp, fault_o, home_angle_flag_o}, 3'b000)
    chk_reg(`SSI_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg(`SSI_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg(`SSI_OFF_STATUS, 32'h0000_F07F, 32'h0000_D010);
    // every resolution with the angle held at home
    for (int i = 1; i <= 7; i++)
    begin
      u_ssi_ctrl_model.set_mode(i[2:0]);
      `CHK({cur_a, cur_b}, {home_tab[i], home_tab[i]})
      `CHK(home_angle_flag_oe_n, 1'b0)
      chk_reg(`SSI_OFF_STATUS, 32'h0000_0700, {21'h0, i[2:0], 8'h00});
    end
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b1, 1'b1);
    `CHK(motor_oe_n, 4'h0)
    u_ssi_ctrl_model.set_ctl(1'b0, 1'b1, 1'b1);
    `CHK(motor_oe_n, 4'hF)
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b0, 1'b1);
    // one cw step per resolution; falling edge must not move the angle
    exp_angle = `SSI_HOME_IDX;
    for (int i = 1; i <= 7; i++)
    begin
      u_ssi_ctrl_model.set_mode(i[2:0]);
      u_ssi_ctrl_model.step_lvl(1'b1, 6);
      exp_angle = exp_angle + inc_tab[i];
      chk_angle();
      u_ssi_ctrl_model.step_lvl(1'b0, 6);
      chk_angle();
      `CHK(home_angle_flag_oe_n, 1'b1)
    end
    // back home, then full steps both ways across the wrap
    u_ssi_ctrl_model.set_mode(3'b001);
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b1, 1'b1);
    exp_angle = `SSI_HOME_IDX;
    chk_angle();
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b0, 1'b1);
    u_ssi_ctrl_model.pulse(1, 6);
    `CHK({out_a_pos, out_a_neg, out_b_pos, out_b_neg}, 4'b0110)
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b0, 1'b0);
    u_ssi_ctrl_model.pulse(1, 6);
    `CHK(home_angle_flag_oe_n, 1'b0)
    u_ssi_ctrl_model.pulse(1, 2);
    exp_angle = 7'h70;
    chk_angle();
    `CHK({out_a_pos, out_a_neg, out_b_pos, out_b_neg}, 4'b1001)
    u_ssi_ctrl_model.set_ctl(1'b1, 1'b0, 1'b1);
    u_ssi_ctrl_model.pulse(4, 2);
    chk_angle();
    // step edges ignored while held by software
    ahb(1'b1, `SSI_OFF_CTRL, 32'h0000_0001, rd);
    u_ssi_ctrl_model.pulse(1, 6);
    chk_angle();
    chk_reg(`SSI_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    // one step per resolution, then 1 + 1 + 1 + 4 across the wrap
    chk_reg(`SSI_OFF_STEPS, 32'hFFFF_FFFF, 32'h0000_000E);
    ahb(1'b1, `SSI_OFF_CTRL, 32'h0000_0000, rd);
    // a frozen block stalls the bus and never sees the step edge
    ce <= 1'b0;
    u_ssi_ctrl_model.pulse(1, 6);
    `CHK(hreadyout, 1'b0)
    ce <= 1'b1;
    chk_angle();
    // faults latch, raise the interrupt, and clear only through standby
    ahb(1'b1, `SSI_OFF_IRQ_STAT, 32'h0000_000F, rd);
    ahb(1'b1, `SSI_OFF_IRQ_MASK, 32'h0000_0002, rd);
    chk_reg(`SSI_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0002);
    `CHK(irq, 1'b0)
    for (int j = 0; j < 2; j++)
    begin
      thermal_shutdown_fault <= (j == 0);
      overcurrent_fault <= (j == 1);
      repeat (6) @(posedge hclk);
      thermal_shutdown_fault <= 1'b0;
      overcurrent_fault <= 1'b0;
      repeat (6) @(posedge hclk);
      `CHK({fault_oe_n, irq}, 2'b01)
      chk_reg(`SSI_OFF_STATUS, 32'h0000_2000, 32'h0000_2000);
      chk_reg(`SSI_OFF_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
      ahb(1'b1, `SSI_OFF_IRQ_STAT, 32'h0000_0002, rd);
      @(posedge hclk);
      `CHK({fault_oe_n, irq}, 2'b00)
      u_ssi_ctrl_model.set_mode(3'b000);
      `CHK(fault_oe_n, 1'b1)
      `CHK({osc_enable, bias_enable, motor_oe_n}, 6'h0F)
      `CHK(irq, 1'b0)
      exp_angle = `SSI_HOME_IDX;
      chk_angle();
      u_ssi_ctrl_model.set_mode(3'b001);
    end
    end_sim();
  end
endmodule
